//--- hdl/rtcp_top.sv
/*
  Holds the real-time counter: APB register file, counter with modulo
  compare, match flag and interrupt request.
  Assumes an APB master on core_clk_in and free-running source clocks.
*/
// The APB interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
module rtcp_top
  import rtcp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [RTCP_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [RTCP_DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [RTCP_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic low_power_osc_clock_in,
  input wire logic external_ref_clock_in,
  input wire logic internal_ref_clock_in,
  input wire logic debug_halt_in,
  output logic match_irq_out
);
  // ==========================================================
  // declarations
  logic flag_q;
  logic flag_d;
  logic irq_en_q;
  logic irq_en_d;
  logic [1:0] clk_src_q;
  logic [3:0] ps_sel_q;
  logic [7:0] mod_q;
  logic [7:0] cnt_q;
  logic [RTCP_DW-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic setup_w;
  logic acc_w;
  logic wr_w;
  logic hit_sc;
  logic hit_cnt;
  logic hit_mod;
  logic mapped_w;
  logic wr_sc;
  logic wr_mod;
  logic [1:0] new_src_w;
  logic [3:0] new_ps_w;
  logic set_chg_w;
  logic clear_w;
  logic tick_w;
  logic match_w;
  logic [7:0] sc_rd_w;
  logic [7:0] rd8_w;

  rtcp_tick_if tick_if();

  // ==========================================================
  // APB decode
  assign setup_w = psel_in && !penable_in;
  assign acc_w = psel_in && penable_in && pready_q;
  assign hit_sc = (paddr_in == RTCP_OFS_SC);
  assign hit_cnt = (paddr_in == RTCP_OFS_CNT);
  assign hit_mod = (paddr_in == RTCP_OFS_MOD);
  assign mapped_w = hit_sc || hit_cnt || hit_mod;
  assign wr_w = acc_w && pwrite_in && pstrb_in[0] && mapped_w;
  assign wr_sc = wr_w && hit_sc;
  assign wr_mod = wr_w && hit_mod;
  assign new_src_w = pwdata_in[RTCP_CLKS_HI:RTCP_CLKS_LO];
  assign new_ps_w = pwdata_in[RTCP_PS_HI:RTCP_PS_LO];

  // a modulo write or a real change of source or prescale restarts counting
  assign set_chg_w = wr_sc && ((new_src_w != clk_src_q) || (new_ps_w != ps_sel_q));
  assign clear_w = wr_mod || set_chg_w;

  assign sc_rd_w = {flag_q, clk_src_q, irq_en_q, ps_sel_q};
  always_comb
  begin
    rd8_w = RTCP_CNT_RST;
    if (hit_sc)
      rd8_w = sc_rd_w;
    else if (hit_cnt)
      rd8_w = cnt_q;
    else if (hit_mod)
      rd8_w = mod_q;
  end

  // ==========================================================
  // APB answer: one wait-free access phase after setup
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !mapped_w;
      if (setup_w && !pwrite_in)
        prdata_q <= RTCP_DW'(rd8_w);
    end
  end

  // ==========================================================
  // control fields
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      irq_en_q <= 1'b0;
      clk_src_q <= RTCP_CLKS_RST;
      ps_sel_q <= RTCP_PS_OFF;
    end
    else if (wr_sc)
    begin
      irq_en_q <= pwdata_in[RTCP_IE_BIT];
      clk_src_q <= new_src_w;
      ps_sel_q <= new_ps_w;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      mod_q <= RTCP_MOD_RST;
    else if (wr_mod)
      mod_q <= pwdata_in[7:0];
  end

  // ==========================================================
  // counter and match
  assign tick_w = tick_if.tick && !clear_w;
  assign match_w = tick_w && (cnt_q == mod_q);

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in || clear_w)
      cnt_q <= RTCP_CNT_RST;
    else if (match_w)
      cnt_q <= RTCP_CNT_RST;
    else if (tick_w)
      cnt_q <= cnt_q + RTCP_CNT_ONE;
  end

  // ==========================================================
  // match flag and request; a match in the clearing cycle wins
  always_comb
  begin
    flag_d = flag_q;
    if (wr_sc && pwdata_in[RTCP_FLAG_BIT])
      flag_d = 1'b0;
    if (match_w)
      flag_d = 1'b1;
    irq_en_d = wr_sc ? pwdata_in[RTCP_IE_BIT] : irq_en_q;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      irq_q <= flag_d && irq_en_d;
    end
  end

  // ==========================================================
  // prescaler
  assign tick_if.src_sel = clk_src_q;
  assign tick_if.ps_sel = ps_sel_q;
  assign tick_if.clear = clear_w;
  assign tick_if.halt = debug_halt_in;

  rtcp_prescaler u_presc (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .src_clk_in({internal_ref_clock_in, external_ref_clock_in, low_power_osc_clock_in}),
    .tick_if(tick_if.presc)
  );

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign match_irq_out = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_flag_on_wrap: assert property (match_w |=> flag_q && cnt_q == RTCP_CNT_RST)
    else $error("match did not set flag and reload count");
  a_flag_w1_clear: assert property (wr_sc && pwdata_in[RTCP_FLAG_BIT] && !match_w
    |=> !flag_q && !match_irq_out)
    else $error("write one did not clear flag and request");
  a_flag_w0_keep: assert property (wr_sc && !pwdata_in[RTCP_FLAG_BIT] && flag_q
    |=> flag_q)
    else $error("write zero changed flag");
  a_reset_values: assert property (@(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> sc_rd_w == RTCP_SC_RST && mod_q == RTCP_MOD_RST && cnt_q == RTCP_CNT_RST)
    else $error("reset values wrong");
  a_irq_follows: assert property (match_irq_out == (flag_q && irq_en_q))
    else $error("request does not follow flag and enable");
  a_irq_gated: assert property (!irq_en_q |-> !match_irq_out)
    else $error("request raised while disabled");
  a_src_chg_clr: assert property (wr_sc && new_src_w != clk_src_q
    |=> cnt_q == RTCP_CNT_RST && !tick_if.tick)
    else $error("source change did not clear counting");
  a_ps_chg_clr: assert property (wr_sc && new_ps_w != ps_sel_q
    |=> cnt_q == RTCP_CNT_RST)
    else $error("prescale change did not clear count");
  a_mod_wr_clr: assert property (wr_mod |=> cnt_q == RTCP_CNT_RST && mod_q == $past(pwdata_in[7:0]))
    else $error("limit write did not clear count");
  a_cnt_ro: assert property (wr_w && hit_cnt && !tick_if.tick |=> $stable(cnt_q))
    else $error("write changed count register");
  a_count_step: assert property (tick_w && cnt_q != mod_q
    |=> cnt_q == $past(cnt_q) + RTCP_CNT_ONE)
    else $error("count did not step by one");
  a_same_keep: assert property (wr_sc && new_src_w == clk_src_q && new_ps_w == ps_sel_q
    && !tick_if.tick |=> $stable(cnt_q))
    else $error("identical rewrite disturbed count");
  a_halt_hold: assert property (debug_halt_in && !tick_if.tick ##1 debug_halt_in && !clear_w
    |=> $stable(cnt_q))
    else $error("count moved during debug halt");
  a_mod0_every: assert property (tick_w && mod_q == RTCP_MOD_RST |=> flag_q)
    else $error("zero limit did not set flag");
  a_apb_ready: assert property (setup_w |=> pready_out ##1 !pready_out)
    else $error("access phase not one cycle");

  c_flag_set: cover property (match_w ##1 flag_q);
  c_irq_raise: cover property (!match_irq_out ##1 match_irq_out);
  c_mod_clear: cover property (wr_mod && cnt_q != RTCP_CNT_RST);
  c_set_w_clr: cover property (match_w && wr_sc && pwdata_in[RTCP_FLAG_BIT]);
endmodule // rtcp_top
`default_nettype wire

//--- common/rtcp_pkg.sv
/*
  Holds the shared constants of the real-time counter: register offsets,
  field positions, reset values and the prescaler divide tables.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`default_nettype none
package rtcp_pkg;
  // ==========================================================
  // bus
  localparam int RTCP_AW = 12;
  localparam int RTCP_DW = 32;
  localparam logic [RTCP_AW-1:0] RTCP_OFS_SC = 12'h000;
  localparam logic [RTCP_AW-1:0] RTCP_OFS_CNT = 12'h004;
  localparam logic [RTCP_AW-1:0] RTCP_OFS_MOD = 12'h008;
  // ==========================================================
  // status and control fields
  localparam int RTCP_FLAG_BIT = 7;
  localparam int RTCP_CLKS_HI = 6;
  localparam int RTCP_CLKS_LO = 5;
  localparam int RTCP_IE_BIT = 4;
  localparam int RTCP_PS_HI = 3;
  localparam int RTCP_PS_LO = 0;
  localparam logic [7:0] RTCP_SC_RST = 8'h00;
  localparam logic [7:0] RTCP_CNT_RST = 8'h00;
  localparam logic [7:0] RTCP_MOD_RST = 8'h00;
  localparam logic [7:0] RTCP_CNT_ONE = 8'h01;
  localparam logic [3:0] RTCP_PS_OFF = 4'h0;
  localparam logic [1:0] RTCP_CLKS_RST = 2'h0;
  // ==========================================================
  // clock sources
  localparam int RTCP_NUM_SRC = 3;
  localparam int RTCP_IDX_LPO = 0;
  localparam int RTCP_IDX_EXT = 1;
  localparam int RTCP_IDX_INT = 2;
  localparam int RTCP_SYNC_N = 3;
  // ==========================================================
  // prescaler divide tables, indexed by prescale_select
  localparam int RTCP_DIV_W = 18;
  typedef logic [RTCP_DIV_W-1:0] rtcp_div_t;
  localparam rtcp_div_t RTCP_DIV_ONE = 18'h00001;
  localparam rtcp_div_t RTCP_DIV_ZERO = 18'h00000;
  localparam rtcp_div_t RTCP_DIV_BANK0 [16] = '{
    18'h00000, 18'h00008, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400,
    18'h00001, 18'h00002, 18'h00004, 18'h0000A, 18'h00010, 18'h00064, 18'h001F4, 18'h003E8};
  localparam rtcp_div_t RTCP_DIV_BANK1 [16] = '{
    18'h00000, 18'h00400, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000,
    18'h003E8, 18'h007D0, 18'h01388, 18'h02710, 18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40};
endpackage
`default_nettype wire

//--- common/rtcp_tick_if.sv
/*
  Carries settings, clear and halt from the register block to the
  prescaler, and the prescaler period tick back.
  Assumes both ends run on the one core clock.
*/
`default_nettype none
interface rtcp_tick_if;
  logic [1:0] src_sel;
  logic [3:0] ps_sel;
  logic clear;
  logic halt;
  logic tick;
  modport ctrl(output src_sel, output ps_sel, output clear, output halt, input tick);
  modport presc(input src_sel, input ps_sel, input clear, input halt, output tick);
endinterface
`default_nettype wire

//--- hdl/rtcp_prescaler.sv
/*
  Holds the source clock synchronisers, source select and the prescaler
  that emits a one-cycle tick at each prescaler period.
  Assumes every source clock is slower than a quarter of core_clk_in.
*/
`default_nettype none
module rtcp_prescaler
  import rtcp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [RTCP_NUM_SRC-1:0] src_clk_in,
  rtcp_tick_if.presc tick_if
);
  logic [RTCP_NUM_SRC-1:0] edge_w;
  logic sel_edge;
  rtcp_div_t div_w;
  rtcp_div_t cnt_q;
  logic tick_q;

  // ==========================================================
  // synchronisers: a rise counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < RTCP_NUM_SRC; g++)
    begin : g_src
      logic [RTCP_SYNC_N-1:0] sync_q;
      logic lvl_q;
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
        begin
          sync_q <= '0;
          lvl_q <= 1'b0;
        end
        else
        begin
          sync_q <= {sync_q[RTCP_SYNC_N-2:0], src_clk_in[g]};
          if (sync_q[RTCP_SYNC_N-2] == sync_q[RTCP_SYNC_N-1])
            lvl_q <= sync_q[RTCP_SYNC_N-1];
        end
      end
      assign edge_w[g] = (sync_q[RTCP_SYNC_N-2] == sync_q[RTCP_SYNC_N-1]) &&
                         sync_q[RTCP_SYNC_N-1] && !lvl_q;
    end
  endgenerate

  // ==========================================================
  // source select and divide value
  always_comb
  begin
    if (tick_if.src_sel[1])
      sel_edge = edge_w[RTCP_IDX_INT];
    else if (tick_if.src_sel[0])
      sel_edge = edge_w[RTCP_IDX_EXT];
    else
      sel_edge = edge_w[RTCP_IDX_LPO];
    div_w = tick_if.src_sel[0] ? RTCP_DIV_BANK1[tick_if.ps_sel]
                               : RTCP_DIV_BANK0[tick_if.ps_sel];
  end

  // ==========================================================
  // prescaler counter
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in || tick_if.clear)
    begin
      cnt_q <= RTCP_DIV_ZERO;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (!tick_if.halt && tick_if.ps_sel != RTCP_PS_OFF && sel_edge)
      begin
        if (cnt_q >= div_w - RTCP_DIV_ONE)
        begin
          cnt_q <= RTCP_DIV_ZERO;
          tick_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + RTCP_DIV_ONE;
      end
    end
  end
  assign tick_if.tick = tick_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_off_no_tick: assert property ((tick_if.ps_sel == RTCP_PS_OFF) |=> !tick_q)
    else $error("prescaler ticked while off");
  a_halt_no_tick: assert property (tick_if.halt |=> !tick_q)
    else $error("prescaler ticked during debug halt");
endmodule // rtcp_prescaler
`default_nettype wire

//--- verif/rtcp_top_tb.sv
/*
  Self-checking bench for the real-time counter: APB register access, counting,
  match flag, interrupt request, halt and prescaler divide ratios.
  Assumes the design answers every APB access and that source clocks may be
  made by dividing the core clock.
*/
`default_nettype none
module rtcp_top_tb
  import rtcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus signals
  logic core_clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [RTCP_AW-1:0] paddr_in = 12'h000;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [RTCP_DW-1:0] pwdata_in = 32'h00000000;
  logic [3:0] pstrb_in = 4'hF;
  logic debug_halt_in = 1'h0;
  logic [2:0] src_q = 3'h0;
  logic [RTCP_DW-1:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic match_irq_out;
  int half_c [3] = '{4, 5, 3};
  int src_cnt [3] = '{0, 0, 0};
  int div0 [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
  int cyc = 0;
  int n_errors = 0;
  int total_checks = 0;
  int prev;
  int wraps;
  logic [7:0] f;
  logic [7:0] c;
  logic [7:0] c0;
  logic e;

  rtcp_top DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .low_power_osc_clock_in(src_q[0]),
    .external_ref_clock_in(src_q[1]), .internal_ref_clock_in(src_q[2]),
    .debug_halt_in(debug_halt_in), .match_irq_out(match_irq_out));

  initial
  begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  // ==========================================================
  // source clocks: periods of 8, 10 and 6 core cycles, all kept running
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++)
    begin
      if (src_cnt[i] == half_c[i] - 1)
      begin
        src_cnt[i] <= 0;
        src_q[i] <= ~src_q[i];
      end
      else
        src_cnt[i] <= src_cnt[i] + 1;
    end
  end
  // ==========================================================
  // reporting
  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("CHECK FAILED %s expected answer seen none", what);
    give_verdict();
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================================
  // bus access: setup, access until pready, release
  task automatic apb_xfer(input logic w, input logic [RTCP_AW-1:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic err);
    int n;
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    @(posedge core_clk_in);
    penable_in <= 1'h1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge core_clk_in);
      if (pready_out === 1'h1)
        break;
    end
    if (n == 16)
      hang("pready");
    q = prdata_out[7:0];
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [RTCP_AW-1:0] a, output logic [7:0] q);
    logic err;
    apb_xfer(1'h0, a, 8'h00, q, err);
  endtask
  task automatic wr(input logic [RTCP_AW-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic err;
    apb_xfer(1'h1, a, d, q, err);
  endtask
  // ==========================================================
  // helpers for counting scenarios
  task automatic wait_flag(output int t);
    logic [7:0] q;
    int n;
    for (n = 0; n < 5000; n++)
    begin
      rd(RTCP_OFS_SC, q);
      if (q[7] === 1'h1)
        break;
    end
    if (n == 5000)
      hang("match flag");
    t = cyc;
  endtask
  task automatic measure(input logic [1:0] cs, input logic [3:0] ps, input int exp);
    int t1;
    int t2;
    logic [7:0] v;
    v = {1'h1, cs, 1'h0, ps};
    wr(RTCP_OFS_SC, v);
    wait_flag(t1);
    wr(RTCP_OFS_SC, v);
    wait_flag(t2);
    check("flag period in range", 1, (t2 - t1 >= exp - 6) && (t2 - t1 <= exp + 6));
  endtask
  // run until the count is nonzero, then freeze it
  task automatic hold_nonzero(output logic [7:0] q);
    debug_halt_in <= 1'h0;
    q = 8'h00;
    for (int n = 0; n < 50 && q == 8'h00; n++)
      rd(RTCP_OFS_CNT, q);
    debug_halt_in <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    rd(RTCP_OFS_CNT, q);
    check("count nonzero before halt", 1, q != 8'h00);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'h0;
    @(posedge core_clk_in);
    rd(RTCP_OFS_SC, f);
    check("status reset", 8'h00, f);
    rd(RTCP_OFS_MOD, f);
    check("modulo reset", 8'h00, f);
    apb_xfer(1'h0, 12'h00C, 8'h00, f, e);
    check("unmapped error", 1'h1, e);
    repeat (100) @(posedge core_clk_in);
    rd(RTCP_OFS_CNT, c);
    check("count with prescaler off", 8'h00, c);
    wr(RTCP_OFS_MOD, 8'h03);
    wr(RTCP_OFS_SC, 8'h18);
    prev = 0;
    wraps = 0;
    for (int n = 0; n < 300 && wraps < 2; n++)
    begin
      rd(RTCP_OFS_SC, f);
      rd(RTCP_OFS_CNT, c);
      if (wraps == 0 && c != 8'h00)
        check("flag before wrap", 1'h0, f[7]);
      if (c != 8'(prev))
        check("count step", 8'((prev + 1) % 4), c);
      if (c == 8'h00 && prev == 3)
        wraps++;
      prev = int'(c);
    end
    check("wraps seen", 2, wraps);
    rd(RTCP_OFS_SC, f);
    check("flag after wrap", 8'h98, f);
    check("irq with flag", 1'h1, match_irq_out);
    wr(RTCP_OFS_SC, 8'h08);
    @(posedge core_clk_in);
    check("irq disabled", 1'h0, match_irq_out);
    rd(RTCP_OFS_SC, f);
    check("flag kept on write 0", 8'h88, f);
    wr(RTCP_OFS_SC, 8'h18);
    wr(RTCP_OFS_MOD, 8'hF0);
    hold_nonzero(c0);
    repeat (50) @(posedge core_clk_in);
    rd(RTCP_OFS_CNT, c);
    check("count held", c0, c);
    wr(RTCP_OFS_CNT, 8'h55);
    wr(RTCP_OFS_SC, 8'h18);
    rd(RTCP_OFS_CNT, c);
    check("count after count write and same setting", c0, c);
    wr(RTCP_OFS_SC, 8'h98);
    @(posedge core_clk_in);
    check("irq cleared", 1'h0, match_irq_out);
    rd(RTCP_OFS_SC, f);
    check("flag cleared", 8'h18, f);
    debug_halt_in <= 1'h0;
    c = c0;
    for (int n = 0; n < 50 && c == c0; n++)
      rd(RTCP_OFS_CNT, c);
    check("count resumes", c0 + 8'h01, c);
    hold_nonzero(c0);
    wr(RTCP_OFS_MOD, 8'hF0);
    rd(RTCP_OFS_CNT, c);
    check("count after limit write", 8'h00, c);
    hold_nonzero(c0);
    wr(RTCP_OFS_SC, 8'h19);
    rd(RTCP_OFS_CNT, c);
    check("count after prescale change", 8'h00, c);
    hold_nonzero(c0);
    wr(RTCP_OFS_SC, 8'h59);
    rd(RTCP_OFS_CNT, c);
    check("count after source change", 8'h00, c);
    debug_halt_in <= 1'h0;
    wr(RTCP_OFS_MOD, 8'h00);
    for (int k = 1; k < 16; k++)
      if (k != 6 && k != 7)
        measure(2'h0, 4'(k), div0[k] * 8);
    measure(2'h1, 4'h8, 1000 * 10);
    measure(2'h2, 4'hD, 100 * 6);
    measure(2'h3, 4'h8, 1000 * 6);
    give_verdict();
  end
endmodule // rtcp_top_tb
`default_nettype wire
